//--- rtl/tmc_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "tmc_regs.svh"

module tmc_timer
  import tmc_pkg::*;
#(
  parameter tmc_variant_t VARIANT     = TMC_COMPACT,
  parameter int           CNT_W       = 10,
  parameter logic [7:0]   PINEN0_MASK = 8'h03,
  parameter logic [7:0]   PINEN1_MASK = 8'h03
) (
  input  wire logic        CLOCK_I,             // system clock
  input  wire logic        RST_B_I,             // async reset, low
  input  wire logic        FH_CLK_I,            // internal high clock
  input  wire logic        TBC_CLK_I,           // time-base clock
  input  wire logic        TCK_PIN_I,           // timer_ext_input_pin
  input  wire logic [5:0]  AVS_ADDRESS_I,       // byte address
  input  wire logic        AVS_READ_I,          // read request
  input  wire logic        AVS_WRITE_I,         // write request
  input  wire logic [31:0] AVS_WRITEDATA_I,     // write data
  input  wire logic [3:0]  AVS_BYTEENABLE_I,    // byte lanes
  output logic      [31:0] AVS_READDATA_O,      // read data
  output logic             AVS_WAITREQUEST_O,   // stall
  output logic      [1:0]  TP_O,                // timer_output_pin
  output logic      [1:0]  TP_OE_O,             // pin handed to timer
  output logic             TCK_CLAIM_O,         // input pin taken
  output logic             IRQ_O                // level interrupt
);

  // ========================================================================
  // input synchronisers
  logic [2:0] async_in;
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] sync3;

  assign async_in = {TCK_PIN_I, TBC_CLK_I, FH_CLK_I};

  generate
    for (genvar g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
          sync1[g] <= 1'b0;
          sync2[g] <= 1'b0;
          sync3[g] <= 1'b0;
        end else begin
          sync1[g] <= async_in[g];
          sync2[g] <= sync1[g];
          sync3[g] <= sync2[g];
        end
      end
    end
  endgenerate

  // ========================================================================
  // registers
  logic [`TMC_CTRL_W-1:0] ctrl;
  logic [CNT_W-1:0]       cmp_a;
  logic [CNT_W-1:0]       cmp_b;
  logic [CNT_W-1:0]       cmp_p;
  logic [CNT_W-1:0]       cnt;
  logic                   dir;
  logic                   on_prev;
  logic [`TMC_FLAG_W-1:0] status;
  logic [`TMC_FLAG_W-1:0] mask;
  logic [7:0]             pinen0;
  logic [7:0]             pinen1;
  logic [1:0]             sys_div;
  logic [5:0]             fh_div;
  logic                   out_a;
  logic                   out_b;
  logic                   claim;
  logic                   irq;
  logic [31:0]            rdata;
  logic                   wait_req;
  tmc_bus_t               bus_st;

  // ========================================================================
  // control decode
  wire       ctrl_on   = ctrl[`TMC_CTRL_ON];
  wire [2:0] ctrl_sel  = ctrl[`TMC_CTRL_SEL_HI:`TMC_CTRL_SEL_LO];
  wire       ctrl_edge = ctrl[`TMC_CTRL_EDGE];
  wire [1:0] ctrl_act  = ctrl[`TMC_CTRL_ACT_HI:`TMC_CTRL_ACT_LO];
  wire       ctrl_clrs = ctrl[`TMC_CTRL_CLRSEL];
  wire [1:0] ctrl_mode = ctrl[`TMC_CTRL_MODE_HI:`TMC_CTRL_MODE_LO];

  wire is_enh   = (VARIANT == TMC_ENHANCED);
  wire is_std   = (VARIANT == TMC_STANDARD);
  wire mode_cmp = (ctrl_mode == TMC_MODE_COMPARE) && !is_enh;
  wire mode_pwm = (ctrl_mode == TMC_MODE_PWM);
  wire mode_cap = (ctrl_mode == TMC_MODE_PULSE) && is_std
                  && ctrl[`TMC_CTRL_CAPT];
  wire mode_spo = (ctrl_mode == TMC_MODE_PULSE) && !mode_cap
                  && (is_std || is_enh);
  wire centre   = is_enh && mode_pwm && ctrl[`TMC_CTRL_CENTRE];

  // ========================================================================
  // clock source selection
  wire fh_rise  = sync2[0] & ~sync3[0];
  wire tb_rise  = sync2[1] & ~sync3[1];
  wire ext_hit  = ctrl_edge ? (~sync2[2] & sync3[2])
                            : (sync2[2] & ~sync3[2]);
  wire t_fsys4  = (sys_div == `TMC_FSYS_DIV_M1);
  wire t_fh16   = fh_rise && (fh_div[3:0] == `TMC_FH16_M1);
  wire t_fh64   = fh_rise && (fh_div == `TMC_FH64_M1);
  logic tick;

  always_comb begin
    case (ctrl_sel)
      `TMC_SEL_FSYS4: tick = t_fsys4;
      `TMC_SEL_FSYS:  tick = 1'b1;
      `TMC_SEL_FH16:  tick = t_fh16;
      `TMC_SEL_FH64:  tick = t_fh64;
      `TMC_SEL_FH:    tick = fh_rise;
      `TMC_SEL_TBC:   tick = tb_rise;
      `TMC_SEL_EXT:   tick = ext_hit;
      default:        tick = 1'b0;
    endcase
  end

  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      sys_div <= 2'h0;
      fh_div  <= 6'h00;
    end else begin
      sys_div <= sys_div + 2'h1;
      fh_div  <= fh_rise ? fh_div + 6'h01 : fh_div;
    end
  end

  // ========================================================================
  // counter and comparators
  wire run       = ctrl_on;
  wire on_rise   = ctrl_on && !on_prev;
  wire step      = run && tick;
  wire match_a   = (cnt == cmp_a);
  wire match_b   = is_enh && (cnt == cmp_b);
  wire match_p   = (cnt == cmp_p);
  wire clear_hit = ctrl_clrs ? match_a : match_p;
  wire cap_ev    = mode_cap && run && ext_hit;
  wire ev_a      = (step && match_a && !mode_cap) || cap_ev;
  wire ev_b      = step && match_b;
  wire ev_p      = step && match_p;
  wire ev_ovf    = step && !centre && !clear_hit && (&cnt);
  logic [CNT_W-1:0] next_cnt;
  logic             next_dir;

  always_comb begin
    next_cnt = cnt;
    next_dir = dir;
    if (on_rise) begin
      next_cnt = '0;
      next_dir = 1'b0;
    end else if (step) begin
      if (centre) begin
        if (!dir && match_p) begin
          next_dir = 1'b1;
          next_cnt = cnt - CNT_W'(1);
        end else if (dir && (cnt == '0)) begin
          next_dir = 1'b0;
          next_cnt = cnt + CNT_W'(1);
        end else begin
          next_cnt = dir ? cnt - CNT_W'(1) : cnt + CNT_W'(1);
        end
      end else if (clear_hit) begin
        next_cnt = '0;
      end else begin
        next_cnt = cnt + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      cnt     <= '0;
      dir     <= 1'b0;
      on_prev <= 1'b0;
    end else begin
      cnt     <= next_cnt;
      dir     <= next_dir;
      on_prev <= ctrl_on;
    end
  end

  // ========================================================================
  // output pins
  logic next_out_a;
  logic next_out_b;

  always_comb begin
    next_out_a = out_a;
    if (mode_pwm) begin
      next_out_a = (next_cnt < cmp_a);
    end else if (mode_spo) begin
      next_out_a = ctrl_on && !(ev_a);
    end else if (mode_cmp && ev_a) begin
      case (ctrl_act)
        `TMC_ACT_LOW:    next_out_a = 1'b0;
        `TMC_ACT_HIGH:   next_out_a = 1'b1;
        `TMC_ACT_TOGGLE: next_out_a = ~out_a;
        default:         next_out_a = out_a;
      endcase
    end
    next_out_b = (is_enh && mode_pwm) ? (next_cnt < cmp_b)
                                      : next_out_a;
  end

  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      out_a <= 1'b0;
      out_b <= 1'b0;
      claim <= 1'b0;
    end else begin
      out_a <= next_out_a;
      out_b <= next_out_b;
      claim <= (ctrl_sel == `TMC_SEL_EXT) || mode_cap;
    end
  end

  // ========================================================================
  // bus decode
  wire        bus_req = AVS_READ_I || AVS_WRITE_I;
  wire        acc     = (bus_st == TMC_BUS_ACK);
  wire        wr_acc  = acc && AVS_WRITE_I;
  wire [31:0] be_mask = {{8{AVS_BYTEENABLE_I[3]}}, {8{AVS_BYTEENABLE_I[2]}},
                         {8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}};
  wire        sel_ctrl = (AVS_ADDRESS_I == `TMC_OFF_CTRL);
  wire        sel_cmpa = (AVS_ADDRESS_I == `TMC_OFF_CMPA);
  wire        sel_cmpb = (AVS_ADDRESS_I == `TMC_OFF_CMPB);
  wire        sel_cmpp = (AVS_ADDRESS_I == `TMC_OFF_CMPP);
  wire        sel_cnt  = (AVS_ADDRESS_I == `TMC_OFF_COUNT);
  wire        sel_stat = (AVS_ADDRESS_I == `TMC_OFF_STATUS);
  wire        sel_mask = (AVS_ADDRESS_I == `TMC_OFF_MASK);
  wire        sel_pe0  = (AVS_ADDRESS_I == `TMC_OFF_PINEN0);
  wire        sel_pe1  = (AVS_ADDRESS_I == `TMC_OFF_PINEN1);

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [31:0] m);
    merge = (old & ~m) | (wd & m);
  endfunction : merge

  wire [31:0] ctrl_z  = {{(32-`TMC_CTRL_W){1'b0}}, ctrl};
  wire [31:0] cmpa_z  = {{(32-CNT_W){1'b0}}, cmp_a};
  wire [31:0] cmpb_z  = {{(32-CNT_W){1'b0}}, cmp_b};
  wire [31:0] cmpp_z  = {{(32-CNT_W){1'b0}}, cmp_p};
  wire [31:0] cnt_z   = {{(32-CNT_W){1'b0}}, cnt};
  wire [31:0] stat_z  = {{(32-`TMC_FLAG_W){1'b0}}, status};
  wire [31:0] mask_z  = {{(32-`TMC_FLAG_W){1'b0}}, mask};
  wire [31:0] pe0_z   = {24'h000000, pinen0};
  wire [31:0] pe1_z   = {24'h000000, pinen1};
  wire [31:0] wr_ctrl = merge(ctrl_z, AVS_WRITEDATA_I, be_mask);
  wire [31:0] wr_cmpa = merge(cmpa_z, AVS_WRITEDATA_I, be_mask);
  wire [31:0] wr_cmpb = merge(cmpb_z, AVS_WRITEDATA_I, be_mask);
  wire [31:0] wr_cmpp = merge(cmpp_z, AVS_WRITEDATA_I, be_mask);
  wire [31:0] wr_mask = merge(mask_z, AVS_WRITEDATA_I, be_mask);
  wire [31:0] wr_pe0  = merge(pe0_z, AVS_WRITEDATA_I, be_mask);
  wire [31:0] wr_pe1  = merge(pe1_z, AVS_WRITEDATA_I, be_mask);
  wire [31:0] w1c     = (wr_acc && sel_stat) ?
                        (AVS_WRITEDATA_I & be_mask) : 32'h00000000;

  wire [31:0] rd_mux =
    sel_ctrl ? ctrl_z :
    sel_cmpa ? cmpa_z :
    sel_cmpb ? (is_enh ? cmpb_z : 32'h00000000) :
    sel_cmpp ? cmpp_z :
    sel_cnt  ? cnt_z  :
    sel_stat ? stat_z :
    sel_mask ? mask_z :
    sel_pe0  ? pe0_z  :
    sel_pe1  ? pe1_z  : 32'h00000000;

  // ========================================================================
  // bus handshake: one wait cycle per access
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      bus_st   <= TMC_BUS_IDLE;
      wait_req <= 1'b1;
      rdata    <= 32'h00000000;
    end else begin
      case (bus_st)
        TMC_BUS_IDLE: begin
          if (bus_req) begin
            bus_st   <= TMC_BUS_ACK;
            wait_req <= 1'b0;
            rdata    <= AVS_READ_I ? rd_mux : 32'h00000000;
          end
        end
        TMC_BUS_ACK: begin
          bus_st   <= TMC_BUS_IDLE;
          wait_req <= 1'b1;
        end
        default: begin
          bus_st   <= TMC_BUS_IDLE;
          wait_req <= 1'b1;
        end
      endcase
    end
  end

  // ========================================================================
  // software registers
  wire [`TMC_FLAG_W-1:0] events;
  wire [`TMC_FLAG_W-1:0] next_status;
  wire                   spo_stop = mode_spo && ev_a;
  wire [`TMC_FLAG_W-1:0] next_mask = (wr_acc && sel_mask) ?
                                     wr_mask[`TMC_FLAG_W-1:0] : mask;

  assign events = {ev_ovf, ev_p, ev_b, ev_a};
  assign next_status = (status & ~w1c[`TMC_FLAG_W-1:0]) | events;

  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ctrl <= '0;
    end else if (wr_acc && sel_ctrl) begin
      ctrl <= wr_ctrl[`TMC_CTRL_W-1:0];
    end else if (spo_stop) begin
      ctrl[`TMC_CTRL_ON] <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      cmp_a <= '0;
      cmp_b <= '0;
      cmp_p <= '0;
    end else begin
      if (cap_ev) begin
        cmp_a <= cnt;
      end else if (wr_acc && sel_cmpa) begin
        cmp_a <= wr_cmpa[CNT_W-1:0];
      end
      if (wr_acc && sel_cmpb && is_enh) begin
        cmp_b <= wr_cmpb[CNT_W-1:0];
      end
      if (wr_acc && sel_cmpp) begin
        cmp_p <= wr_cmpp[CNT_W-1:0];
      end
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      status <= '0;
      mask   <= '0;
      irq    <= 1'b0;
      pinen0 <= `TMC_PINEN_RST & PINEN0_MASK;
      pinen1 <= `TMC_PINEN_RST & PINEN1_MASK;
    end else begin
      status <= next_status;
      irq    <= |(next_status & next_mask);
      if (wr_acc && sel_mask) begin
        mask <= wr_mask[`TMC_FLAG_W-1:0];
      end
      if (wr_acc && sel_pe0) begin
        pinen0 <= wr_pe0[7:0] & PINEN0_MASK;
      end
      if (wr_acc && sel_pe1) begin
        pinen1 <= wr_pe1[7:0] & PINEN1_MASK;
      end
    end
  end

  // ========================================================================
  // outputs
  assign AVS_READDATA_O    = rdata;
  assign AVS_WAITREQUEST_O = wait_req;
  assign TP_O              = {out_b, out_a};
  assign TP_OE_O           = pinen0[1:0];
  assign TCK_CLAIM_O       = claim;
  assign IRQ_O             = irq;

endmodule : tmc_timer
`default_nettype wire

//--- inc/tmc_regs.svh
`ifndef TMC_REGS_SVH
`define TMC_REGS_SVH

// ==========================================================================
// register byte offsets
`define TMC_OFF_CTRL    6'h00
`define TMC_OFF_CMPA    6'h04
`define TMC_OFF_CMPB    6'h08
`define TMC_OFF_CMPP    6'h0C
`define TMC_OFF_COUNT   6'h10
`define TMC_OFF_STATUS  6'h14
`define TMC_OFF_MASK    6'h18
`define TMC_OFF_PINEN0  6'h1C
`define TMC_OFF_PINEN1  6'h20

// ==========================================================================
// control register fields
`define TMC_CTRL_W       12
`define TMC_CTRL_ON      0
`define TMC_CTRL_SEL_LO  1
`define TMC_CTRL_SEL_HI  3
`define TMC_CTRL_EDGE    4
`define TMC_CTRL_ACT_LO  5
`define TMC_CTRL_ACT_HI  6
`define TMC_CTRL_CLRSEL  7
`define TMC_CTRL_MODE_LO 8
`define TMC_CTRL_MODE_HI 9
`define TMC_CTRL_CENTRE  10
`define TMC_CTRL_CAPT    11

// ==========================================================================
// clock select codes
`define TMC_SEL_FSYS4    3'h0
`define TMC_SEL_FSYS     3'h1
`define TMC_SEL_FH16     3'h2
`define TMC_SEL_FH64     3'h3
`define TMC_SEL_FH       3'h4
`define TMC_SEL_RSVD     3'h5
`define TMC_SEL_TBC      3'h6
`define TMC_SEL_EXT      3'h7

// ==========================================================================
// output actions, status bits, reset values, dividers
`define TMC_ACT_NONE     2'h0
`define TMC_ACT_LOW      2'h1
`define TMC_ACT_HIGH     2'h2
`define TMC_ACT_TOGGLE   2'h3
`define TMC_FLAG_W       4
`define TMC_FLAG_A       0
`define TMC_FLAG_B       1
`define TMC_FLAG_P       2
`define TMC_FLAG_OVF     3
`define TMC_PINEN_RST    8'h01
`define TMC_FSYS_DIV_M1  2'h3
`define TMC_FH16_M1      4'hF
`define TMC_FH64_M1      6'h3F

`endif

//--- inc/tmc_pkg.sv
package tmc_pkg;

  typedef enum logic [1:0] {
    TMC_COMPACT  = 2'h0,
    TMC_STANDARD = 2'h1,
    TMC_ENHANCED = 2'h2
  } tmc_variant_t;

  typedef enum logic [1:0] {
    TMC_MODE_COMPARE = 2'h0,
    TMC_MODE_TIMER   = 2'h1,
    TMC_MODE_PWM     = 2'h2,
    TMC_MODE_PULSE   = 2'h3
  } tmc_mode_t;

  typedef enum logic [1:0] {
    TMC_BUS_IDLE = 2'b01,
    TMC_BUS_ACK  = 2'b10
  } tmc_bus_t;

endpackage : tmc_pkg

//--- tb/tmc_timer_sva.sv
`timescale 1ns/10ps
`default_nettype none
`include "tmc_regs.svh"

module tmc_timer_sva #(
  parameter logic [7:0] PINEN0_MASK = 8'h03
) (
  input wire logic        CLOCK_I,           // clock
  input wire logic        RST_B_I,           // reset, low
  input wire logic [5:0]  AVS_ADDRESS_I,     // address
  input wire logic        AVS_READ_I,        // read
  input wire logic        AVS_WRITE_I,       // write
  input wire logic [31:0] AVS_WRITEDATA_I,   // write data
  input wire logic [3:0]  AVS_BYTEENABLE_I,  // lanes
  input wire logic [31:0] AVS_READDATA_O,    // read data
  input wire logic        AVS_WAITREQUEST_O, // stall
  input wire logic [1:0]  TP_OE_O,           // pin enables
  input wire logic        TCK_CLAIM_O,       // input taken
  input wire logic        IRQ_O              // interrupt
);
  // ==========================================================
  // helper state
  logic [1:0] oe_exp;
  logic       claim_exp;
  wire  logic wr_take = AVS_WRITE_I && !AVS_WAITREQUEST_O;
  wire  logic rd_take = AVS_READ_I && !AVS_WAITREQUEST_O;

  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      oe_exp    <= 2'h0;
      claim_exp <= 1'b0;
    end else if (wr_take && AVS_ADDRESS_I == `TMC_OFF_PINEN0) begin
      oe_exp <= AVS_WRITEDATA_I[1:0] & PINEN0_MASK[1:0];
    end else if (wr_take && AVS_ADDRESS_I == `TMC_OFF_CTRL) begin
      claim_exp <= AVS_WRITEDATA_I[3:1] == `TMC_SEL_EXT;
    end
  end

  // ==========================================================
  // properties
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_B_I);

  sequence s_req;
    (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O;
  endsequence
  sequence s_take(logic [5:0] a);
    wr_take && AVS_BYTEENABLE_I[0] && AVS_ADDRESS_I == a;
  endsequence

  a_wait_pulse: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
    else $error("waitrequest low longer than one cycle");
  a_req_answer: assert property (s_req |=> !AVS_WAITREQUEST_O)
    else $error("request not answered next cycle");
  a_wait_cause: assert property ($fell(AVS_WAITREQUEST_O) |->
    $past(AVS_READ_I) || $past(AVS_WRITE_I))
    else $error("waitrequest dropped without request");
  a_unmapped_zero: assert property (rd_take && AVS_ADDRESS_I > 6'h20 |->
    AVS_READDATA_O == 32'h0) else $error("unmapped read not zero");
  a_pinen_bits: assert property (
    rd_take && AVS_ADDRESS_I == `TMC_OFF_PINEN0 |->
    (AVS_READDATA_O & ~{24'h0, PINEN0_MASK}) == 32'h0)
    else $error("unimplemented enable bits set");
  a_oe_follow: assert property (s_take(`TMC_OFF_PINEN0) |->
    ##[1:2] TP_OE_O == oe_exp) else $error("pin enable not applied");
  a_oe_reset: assert property ($rose(RST_B_I) |->
    TP_OE_O == (2'b01 & PINEN0_MASK[1:0]))
    else $error("pin enable reset value wrong");
  a_claim_sel: assert property (s_take(`TMC_OFF_CTRL) |->
    ##[1:2] TCK_CLAIM_O == claim_exp) else $error("input claim wrong");
  a_irq_masked: assert property (s_take(`TMC_OFF_MASK) ##0
    (AVS_WRITEDATA_I[3:0] == 4'h0) |-> ##2 !IRQ_O)
    else $error("interrupt high with all masked");
endmodule : tmc_timer_sva

bind tmc_timer tmc_timer_sva #(.PINEN0_MASK(PINEN0_MASK)) i_tmc_timer_sva (
  .CLOCK_I(CLOCK_I), .RST_B_I(RST_B_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
  .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
  .AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I),
  .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
  .TP_OE_O(TP_OE_O), .TCK_CLAIM_O(TCK_CLAIM_O), .IRQ_O(IRQ_O));
`default_nettype wire

//--- tb/tmc_pin_model.sv
`timescale 1ns/10ps
`default_nettype none

module tmc_pin_model (
  input  wire logic       clk_i,  // system clock
  input  wire logic       go_i,   // start a burst
  input  wire logic [3:0] n_i,    // level changes
  output logic            pin_o,  // external timer input
  output logic            busy_o  // burst running
);
  // ==========================================================
  // levels held 2 to 4 clocks, steady between bursts
  initial begin
    pin_o = 1'b0;
    busy_o = 1'b0;
    forever begin
      @(posedge clk_i);
      if (go_i) begin
        busy_o <= 1'b1;
        for (int k = 0; k < int'(n_i); k++) begin
          repeat (2 + k % 3) @(posedge clk_i);
          pin_o <= ~pin_o;
        end
        repeat (5) @(posedge clk_i);
        busy_o <= 1'b0;
      end
    end
  end
endmodule : tmc_pin_model
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "tmc_regs.svh"

module testbench
  import tmc_pkg::*;
;
  typedef struct {string nm; logic [31:0] v; logic [31:0] m;} tmc_note_t;
  logic        clk, rst_b, fh, tbc, pin, busy, go, rd_r, wr_r;
  logic        wreq, claim, irq;
  logic [3:0]  n, be;
  logic [5:0]  addr;
  logic [31:0] wdata, rdata;
  logic [1:0]  tp, tp_oe;
  tmc_note_t   notes[$];
  int          fails, num_checks;

  tmc_timer #(.VARIANT(TMC_COMPACT), .CNT_W(10)) i_tmc_timer (
    .CLOCK_I(clk), .RST_B_I(rst_b), .FH_CLK_I(fh), .TBC_CLK_I(tbc),
    .TCK_PIN_I(pin), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd_r),
    .AVS_WRITE_I(wr_r), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wreq), .TP_O(tp),
    .TP_OE_O(tp_oe), .TCK_CLAIM_O(claim), .IRQ_O(irq));
  tmc_pin_model i_tmc_pin_model (
    .clk_i(clk), .go_i(go), .n_i(n), .pin_o(pin), .busy_o(busy));

  always #5 clk = ~clk;
  always #25 fh = ~fh;
  always #95 tbc = ~tbc;

  // ==========================================================
  // checking
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report

  always @(posedge clk) begin
    if (rd_r && wreq === 1'b0 && notes.size() > 0) begin
      if (notes[0].m != 0)
        chk(notes[0].nm, rdata & notes[0].m, notes[0].v & notes[0].m);
      void'(notes.pop_front());
    end
  end

  // ==========================================================
  // bus master
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_r  <= w;
    rd_r  <= !w;
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    q = rdata;
    rd_r <= 1'b0;
    wr_r <= 1'b0;
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [5:0] a, input string nm,
                    input logic [31:0] v, m, output logic [31:0] q);
    notes.push_back('{nm, v, m});
    bus(1'b0, a, 32'h0, q);
  endtask : rd

  function automatic logic [31:0] ctrl(input logic on, input logic [2:0] s,
      input logic e, input logic [1:0] act, input logic clr,
      input logic [1:0] m);
    ctrl = {22'h0, m, clr, act, e, s, on};
  endfunction : ctrl

  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    final_report();
  end

  // ==========================================================
  // scenarios
  initial begin
    logic [31:0] d, q, c;
    logic        st;
    logic [1:0]  acts [4];
    logic        pexp [3];
    acts = '{`TMC_ACT_HIGH, `TMC_ACT_LOW, `TMC_ACT_TOGGLE, `TMC_ACT_NONE};
    pexp = '{1'b1, 1'b0, 1'b1};
    {clk, rst_b, fh, tbc, go, rd_r, wr_r} = '0;
    {addr, wdata, n} = '0;
    be = 4'hF;
    void'($urandom(32'h4244));
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    chk("oe reset", 32'(tp_oe), 32'h1);
    chk("irq reset", 32'(irq), 32'h0);
    rd(`TMC_OFF_PINEN0, "pinen0 reset", 32'h1, '1, q);
    for (int i = 0; i < 4; i++) begin
      d = $urandom;
      wr(`TMC_OFF_PINEN0, d);
      wr(`TMC_OFF_PINEN1, ~d);
      rd(`TMC_OFF_PINEN0, "pinen0", d & 32'h3, '1, q);
      rd(`TMC_OFF_PINEN1, "pinen1", ~d & 32'h3, '1, q);
      chk("oe", 32'(tp_oe), d & 32'h3);
    end
    wr(6'h24, 32'hFFFF_FFFF);
    rd(6'h24, "unmapped", 32'h0, '1, q);
    wr(`TMC_OFF_CMPB, 32'h3FF);
    rd(`TMC_OFF_CMPB, "cmpb absent", 32'h0, '1, q);
    wr(`TMC_OFF_CMPA, 32'hFFFF);
    rd(`TMC_OFF_CMPA, "cmpa width", 32'h3FF, '1, q);
    wr(`TMC_OFF_CMPP, 32'h3FF);
    for (int s = 0; s < 8; s++) begin
      wr(`TMC_OFF_CTRL, ctrl(1'b0, 3'(s), 1'b0, 2'h0, 1'b0, 2'h1));
      wr(`TMC_OFF_CTRL, ctrl(1'b1, 3'(s), 1'b0, 2'h0, 1'b0, 2'h1));
      repeat (400) @(posedge clk);
      rd(`TMC_OFF_COUNT, "count", 32'h0, 32'h0, q);
      chk("count runs", 32'(q != 0), 32'(s != 5 && s != 7));
      chk("claim", 32'(claim), 32'(s == 7));
    end
    for (int e = 0; e < 2; e++) begin
      wr(`TMC_OFF_CTRL, ctrl(1'b0, `TMC_SEL_EXT, 1'(e), 2'h0, 1'b0, 2'h1));
      wr(`TMC_OFF_CTRL, ctrl(1'b1, `TMC_SEL_EXT, 1'(e), 2'h0, 1'b0, 2'h1));
      st = pin;
      d = 1 + $urandom % 8;
      n <= 4'(d);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (2) @(posedge clk);
      while (busy === 1'b1) @(posedge clk);
      c = (st == 1'(e)) ? (d + 1) / 2 : d / 2;
      rd(`TMC_OFF_COUNT, "edges", c, 32'h3FF, q);
      chk("claim ext", 32'(claim), 32'h1);
    end
    wr(`TMC_OFF_CTRL, 32'h0);
    wr(`TMC_OFF_STATUS, 32'hF);
    for (int i = 0; i < 4; i++) begin
      c = 8 + $urandom % 33;
      wr(`TMC_OFF_CMPA, i < 3 ? c : 32'h3FE);
      wr(`TMC_OFF_CMPP, i < 3 ? 32'h3FF : c);
      wr(`TMC_OFF_MASK, i < 3 ? 32'h1 : 32'h4);
      wr(`TMC_OFF_CTRL, ctrl(1'b1, `TMC_SEL_FSYS, 1'b0, acts[i], 1'(i < 3),
                             2'h0));
      for (int k = 0; k < 2000 && irq !== 1'b1; k++) @(posedge clk);
      wr(`TMC_OFF_CTRL, ctrl(1'b0, `TMC_SEL_FSYS, 1'b0, 2'h0, 1'b0, 2'h0));
      chk("irq", 32'(irq), 32'h1);
      rd(`TMC_OFF_STATUS, "status", i < 3 ? 1 : 4, 32'hF, q);
      if (i < 3)
        chk("pin", 32'(tp), {30'h0, {2{pexp[i]}}});
      wr(`TMC_OFF_MASK, 32'h0);
      repeat (2) @(posedge clk);
      chk("irq masked", 32'(irq), 32'h0);
      wr(`TMC_OFF_STATUS, 32'hF);
      rd(`TMC_OFF_STATUS, "status clear", 32'h0, 32'hF, q);
    end
    for (int k = 0; k < 2; k++) begin
      wr(`TMC_OFF_CMPA, 32'(5 * k));
      wr(`TMC_OFF_CTRL, ctrl(1'b1, `TMC_SEL_RSVD, 1'b0, 2'h0, 1'b0, 2'h2));
      repeat (2) @(posedge clk);
      chk("pwm", 32'(tp), 32'(3 * k));
    end
    wr(`TMC_OFF_CTRL, ctrl(1'b1, `TMC_SEL_FSYS, 1'b0, 2'h3, 1'b1, 2'h3));
    repeat (40) @(posedge clk);
    chk("no pulse", 32'({claim, tp}), 32'h3);
    final_report();
  end
endmodule : testbench
`default_nettype wire
